// ==== design/mii_pin_strap_led_logic.sv ====
/*
 * Transceiver pin logic: MII/RMII transmit capture, RMII receive
 * dibits, collision and carrier pins, strap capture and indicators.
 * Assumes the link clock is far slower than core_clk and is sampled.
 */
module mii_pin_strap_led_logic
	import mii_strap_pkg::*;
#(
	parameter int unsigned BLINK_CYCLES = BLINK_CYCLES_DEF
) (
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       reset_n,
	// link pins from the mac
	input  wire logic       link_clk,
	input  wire logic       tx_en,
	input  wire logic [3:0] txd,
	input  wire logic       rmii_mode,
	// collision pin, carrier sense pin and mode strap bit 2
	input  wire logic       mode_strap_bit0_in,
	output logic            col_out,
	output logic            col_oe,
	input  wire logic       mode_strap_bit1_in,
	output logic            crs_out,
	output logic            crs_oe,
	input  wire logic       mode_strap_bit2_in,
	// indicator pins
	input  wire logic       autoneg_enable_strap,
	output logic            link_indicator_out,
	output logic            link_indicator_oe,
	input  wire logic       speed_strap_in,
	output logic            speed_activity_indicator_out,
	output logic            speed_activity_indicator_oe,
	// rmii receive pins
	output logic [1:0]      rmii_rxd,
	output logic            rmii_crs_dv,
	// core status and control
	input  wire logic       collision_det,
	input  wire logic       carrier_sense,
	input  wire logic       link_up,
	input  wire logic       activity,
	input  wire logic       speed_100,
	input  wire logic [1:0] led_mode,
	// core receive dibit source
	input  wire logic       rx_dibit_valid,
	input  wire logic [1:0] rx_dibit,
	output logic            rx_dibit_ready,
	// core results
	output tx_beat_t        tx_beat,
	output strap_t          straps,
	output logic            speed_select,
	output logic            strap_done
);
	localparam int unsigned BW = $clog2(BLINK_CYCLES + 1);
	logic [SYNC_W-1:0] sync_q;
	logic [SYNC_W-1:0] prev_reg;
	wire logic         rise   = sync_q[P_LCLK] & ~prev_reg[P_LCLK]; // link edge
	wire logic         p_txen = prev_reg[P_TXEN];
	wire logic [3:0]   p_txd  = prev_reg[P_TXD +: 4];
	// every pin level except rmii_mode crosses through two flops first
	pin_sync2 #(.WIDTH(SYNC_W)) u_sync (
		.clk     (core_clk),
		.reset_n (reset_n),
		.d       ({link_clk, tx_en, txd, mode_strap_bit2_in,
		           mode_strap_bit0_in, mode_strap_bit1_in,
		           autoneg_enable_strap, speed_strap_in}),
		.q       (sync_q)
	);

	// previous sample: data seen just before the clock edge is stable
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			prev_reg <= '0;
		else
			prev_reg <= sync_q;
	end

	// transmit capture: nibbles in mii, dibit pairs in rmii
	tx_beat_t   tx_beat_reg, tx_beat_next;
	logic [1:0] lo_reg, lo_next;
	logic       have_reg, have_next;
	always_comb begin
		tx_beat_next = '{valid: 1'b0, data: tx_beat_reg.data};
		lo_next      = lo_reg;
		have_next    = have_reg;
		if (rise) begin
			if (!p_txen) begin
				have_next = 1'b0; // RULE2
			end else if (!rmii_mode) begin
				tx_beat_next = '{valid: 1'b1, data: p_txd}; // RULE2
			end else if (!have_reg) begin
				lo_next   = p_txd[1:0];
				have_next = 1'b1;
			end else begin
				tx_beat_next = '{valid: 1'b1, data: {p_txd[1:0], lo_reg}};
				have_next    = 1'b0;
			end
		end
	end
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_beat_reg <= '0;
			lo_reg      <= 2'h0;
			have_reg    <= 1'b0;
		end else begin
			tx_beat_reg <= tx_beat_next;
			lo_reg      <= lo_next;
			have_reg    <= have_next;
		end
	end
	// rmii receive: one dibit presented per reference clock rise
	logic [1:0] rxd_reg, rxd_next;
	logic       crs_dv_reg, crs_dv_next;
	logic       ready_reg, ready_next;
	always_comb begin
		rxd_next    = rxd_reg;
		crs_dv_next = crs_dv_reg;
		ready_next  = 1'b0;
		if (!rmii_mode) begin
			rxd_next    = 2'h0;
			crs_dv_next = 1'b0;
		end else if (rise) begin
			crs_dv_next = rx_dibit_valid; // RULE11
			rxd_next    = rx_dibit_valid ? rx_dibit : 2'h0;
			ready_next  = rx_dibit_valid;
		end
	end
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rxd_reg    <= 2'h0;
			crs_dv_reg <= 1'b0;
			ready_reg  <= 1'b0;
		end else begin
			rxd_reg    <= rxd_next;
			crs_dv_reg <= crs_dv_next;
			ready_reg  <= ready_next;
		end
	end

	// strap capture once the released pins have settled
	strap_state_t state_reg, state_next;
	logic [1:0]   cnt_reg, cnt_next;
	strap_t       straps_reg, straps_next;
	logic         speed_sel_reg, speed_sel_next;
	logic [2:0]   code;
	logic         done;
	assign code = {sync_q[P_STRAP2], sync_q[P_CRS], sync_q[P_COL]}; // RULE5
	assign done = (state_reg == STRAP_RUN);
	always_comb begin
		state_next     = state_reg;
		cnt_next       = cnt_reg;
		straps_next    = straps_reg;
		speed_sel_next = speed_sel_reg;
		unique case (state_reg)
			STRAP_SAMPLE: begin
				if (cnt_reg == STRAP_SETTLE) begin
					straps_next.mode_code = code;
					if (code == MODE_CODE_MII) // RULE13
						straps_next.if_mode = IF_MII;
					else if (code == MODE_CODE_B2B)
						straps_next.if_mode = IF_B2B;
					else
						straps_next.if_mode = IF_RESERVED;
					straps_next.autoneg_enable = sync_q[P_LINK_INDICATOR_OUT]; // RULE14
					straps_next.speed_100 = sync_q[P_SPEED_ACTIVITY_INDICATOR_OUT]; // RULE15
					speed_sel_next = sync_q[P_SPEED_ACTIVITY_INDICATOR_OUT]; // RULE10
					state_next = STRAP_RUN; // RULE16
				end else begin
					cnt_next = cnt_reg + 2'h1;
				end
			end
			STRAP_RUN: state_next = STRAP_RUN; // RULE16
		endcase
	end
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg     <= STRAP_SAMPLE;
			cnt_reg       <= 2'h0;
			straps_reg    <= '0;
			speed_sel_reg <= 1'b0;
		end else begin
			state_reg     <= state_next;
			cnt_reg       <= cnt_next;
			straps_reg    <= straps_next;
			speed_sel_reg <= speed_sel_next;
		end
	end

	// indicators, blink timer and pin drivers
	logic [BW-1:0] blink_cnt_reg, blink_cnt_next;
	logic          blink_reg, blink_next;
	logic          link_indicator_out_reg, link_indicator_out_next, speed_activity_indicator_out_reg, speed_activity_indicator_out_next;
	logic          col_reg, crs_reg, col_oe_reg, crs_oe_reg, led_oe_reg;
	always_comb begin
		blink_cnt_next = blink_cnt_reg + BW'(1);
		blink_next     = blink_reg;
		if (!activity) begin
			blink_cnt_next = '0;
			blink_next     = 1'b1;
		end else if (blink_cnt_reg == BW'(BLINK_CYCLES - 1)) begin
			blink_cnt_next = '0;
			blink_next     = ~blink_reg;
		end
		link_indicator_out_next = 1'b1;
		speed_activity_indicator_out_next = 1'b1;
		if (led_mode == LED_MODE_0) begin // RULE9
			link_indicator_out_next = !link_up ? 1'b1 : (activity & blink_reg); // RULE7
			speed_activity_indicator_out_next = ~speed_100; // RULE8
		end else if (led_mode == LED_MODE_1) begin
			link_indicator_out_next = ~link_up; // RULE7
			speed_activity_indicator_out_next = activity ? blink_reg : 1'b1; // RULE8
		end
	end
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			blink_cnt_reg <= '0;
			blink_reg     <= 1'b1;
			link_indicator_out_reg      <= 1'b1;
			speed_activity_indicator_out_reg      <= 1'b1;
			col_reg       <= 1'b0;
			crs_reg       <= 1'b0;
			col_oe_reg    <= 1'b0;
			crs_oe_reg    <= 1'b0;
			led_oe_reg    <= 1'b0;
		end else begin
			blink_cnt_reg <= blink_cnt_next;
			blink_reg     <= blink_next;
			link_indicator_out_reg      <= link_indicator_out_next;
			speed_activity_indicator_out_reg      <= speed_activity_indicator_out_next;
			col_reg       <= collision_det; // RULE3
			crs_reg       <= carrier_sense; // RULE4
			col_oe_reg    <= done & ~rmii_mode; // RULE3 RULE6
			crs_oe_reg    <= done & ~rmii_mode; // RULE4 RULE6
			led_oe_reg    <= done; // RULE6
		end
	end
	assign col_out                      = col_reg;
	assign col_oe                       = col_oe_reg;
	assign crs_out                      = crs_reg;
	assign crs_oe                       = crs_oe_reg;
	assign link_indicator_out           = link_indicator_out_reg;
	assign link_indicator_oe            = led_oe_reg;
	assign speed_activity_indicator_out = speed_activity_indicator_out_reg;
	assign speed_activity_indicator_oe  = led_oe_reg;
	assign rmii_rxd                     = rxd_reg;
	assign rmii_crs_dv                  = crs_dv_reg;
	assign rx_dibit_ready               = ready_reg;
	assign tx_beat                      = tx_beat_reg;
	assign straps                       = straps_reg;
	assign speed_select                 = speed_sel_reg;
	assign strap_done                   = done;
	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	tx_ignore_a: assert property (rise && !p_txen |=> !tx_beat.valid) // RULE2
		else $error("beat taken while enable low");
	tx_nibble_a: assert property (rise && p_txen && !rmii_mode // RULE2
		|=> tx_beat.valid && tx_beat.data == $past(p_txd))
		else $error("mii nibble not captured");
	col_drive_a: assert property ($past(done) && !$past(rmii_mode) // RULE3
		|-> col_oe && col_out == $past(collision_det))
		else $error("collision pin not driven");
	crs_drive_a: assert property ($past(done) && !$past(rmii_mode) // RULE4
		|-> crs_oe && crs_out == $past(carrier_sense))
		else $error("carrier pin not driven");
	strap_code_a: assert property ($rose(done) // RULE5
		|-> straps.mode_code == $past(code))
		else $error("mode strap mismatch");
	strap_float_a: assert property (!$past(done) // RULE6
		|-> !col_oe && !crs_oe && !link_indicator_oe)
		else $error("strap pin driven before capture");
	strap_hold_a: assert property (done && $past(done) // RULE16
		|-> $stable(straps) && $stable(speed_select))
		else $error("strap changed after capture");
	if_mode_a: assert property (done // RULE13
		|-> (straps.mode_code == MODE_CODE_B2B) == (straps.if_mode == IF_B2B))
		else $error("interface mode decode wrong");
	autoneg_a: assert property ($rose(done) // RULE14
		|-> straps.autoneg_enable == $past(sync_q[P_LINK_INDICATOR_OUT]))
		else $error("autoneg strap wrong");
	speed_sel_a: assert property ($rose(done) // RULE10 RULE15
		|-> speed_select == $past(sync_q[P_SPEED_ACTIVITY_INDICATOR_OUT]) && straps.speed_100 == speed_select)
		else $error("speed strap wrong");
	link_indicator_out_link_a: assert property (led_mode == LED_MODE_1 // RULE7 RULE9
		|=> link_indicator_out == !$past(link_up))
		else $error("link indicator wrong");
	speed_activity_indicator_out_speed_a: assert property (led_mode == LED_MODE_0 // RULE8
		|=> speed_activity_indicator_out == !$past(speed_100))
		else $error("speed indicator wrong");
	rx_dibit_a: assert property (rise && rmii_mode && rx_dibit_valid // RULE11
		|=> rmii_crs_dv && rx_dibit_ready && rmii_rxd == $past(rx_dibit))
		else $error("rmii dibit not sent");
	strap_cov_c: cover property ($rose(done));
	rmii_pair_c: cover property (rmii_mode && tx_beat.valid);
	blink_cov_c: cover property (activity && $changed(blink_reg));
	rx_cov_c:    cover property (rx_dibit_ready ##1 rx_dibit_valid);
endmodule

// ==== design/mii_strap_pkg.sv ====
/*
 * Shared constants and carrier types for the transceiver pin logic:
 * strap timing, mode codes, indicator modes, pin sampling positions.
 * Assumes a 250 MHz core clock; the link clock is sampled, not used.
 */
// How it works
// RULE1: MAC drives the four transmit data lines in step with the link clock.
// RULE2: Transmit data counts only while transmit enable is high; otherwise ignored.
// RULE3: In MII mode the collision pin is driven toward the MAC.
// RULE4: In MII mode the carrier sense pin is driven toward the MAC.
// RULE5: At reset release collision pin gives mode bit 0, carrier pin bit 1.
// RULE6: Strap pins float as inputs in reset, become driven outputs afterward; the code drives the collision and carrier pins only when rmii_mode is low.
// RULE7: First indicator: mode 00 link/activity blink, mode 01 link only.
// RULE8: Second indicator: mode 00 speed, mode 01 activity blink; 10, 11 reserved.
// RULE9: A two-bit management field picks the mode of both indicators.
// RULE10: Second indicator pin at reset release loads the speed-select bit.
// RULE11: RMII receive sends two bits per reference clock while valid is high.
// RULE12: MAC sends two transmit bits per reference clock while enable is high.
// RULE13: Mode code 000 means MII, 110 back-to-back; other codes reserved.
// RULE14: First indicator pin at reset release enables auto-negotiation when high.
// RULE15: Second indicator pin at reset release selects 100 Mbps when high.
// RULE16: Straps sampled once after reset release, held until the next reset.
package mii_strap_pkg;
	// core clock and indicator blink timing
	localparam int unsigned CLK_PERIOD_NS    = 4;
	localparam int unsigned BLINK_TIME_NS    = 40000000;
	localparam int unsigned BLINK_CYCLES_DEF = BLINK_TIME_NS / CLK_PERIOD_NS;
	// cycles after release before pin levels have passed the synchroniser
	localparam logic [1:0]  STRAP_SETTLE     = 2'h2;
	// interface mode strap codes
	localparam logic [2:0]  MODE_CODE_MII    = 3'h0;
	localparam logic [2:0]  MODE_CODE_B2B    = 3'h6;
	// indicator mode field values
	localparam logic [1:0]  LED_MODE_0       = 2'h0;
	localparam logic [1:0]  LED_MODE_1       = 2'h1;
	// positions in the synchronised pin vector
	localparam int unsigned SYNC_W   = 11;
	localparam int unsigned P_LCLK   = 10;
	localparam int unsigned P_TXEN   = 9;
	localparam int unsigned P_TXD    = 5;
	localparam int unsigned P_STRAP2 = 4;
	localparam int unsigned P_COL    = 3;
	localparam int unsigned P_CRS    = 2;
	localparam int unsigned P_LINK_INDICATOR_OUT   = 1;
	localparam int unsigned P_SPEED_ACTIVITY_INDICATOR_OUT   = 0;

	typedef enum logic [1:0] {
		IF_MII      = 2'b00,
		IF_B2B      = 2'b01,
		IF_RESERVED = 2'b10
	} if_mode_t;

	typedef enum logic {
		STRAP_SAMPLE = 1'b0,
		STRAP_RUN    = 1'b1
	} strap_state_t;

	typedef struct packed {
		logic       valid;
		logic [3:0] data;
	} tx_beat_t;

	typedef struct packed {
		logic [2:0] mode_code;
		if_mode_t   if_mode;
		logic       autoneg_enable;
		logic       speed_100;
	} strap_t;
endpackage

// ==== design/pin_sync2.sv ====
/*
 * Two-flop synchroniser for a vector of independent pin levels.
 * Assumes each bit is a slow level; bits are not coherent with each other.
 */
module pin_sync2 #(
	parameter int unsigned WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             reset_n,
	// asynchronous levels in, synchronised levels out
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] q_reg;

	// first stage is read only by the second
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_reg <= '0;
			q_reg    <= '0;
		end else begin
			meta_reg <= d;
			q_reg    <= meta_reg;
		end
	end

	assign q = q_reg;
endmodule

// ==== testbench/mac_model.sv ====
/*
 * Behavioural MAC transmit side: makes the link clock and drives
 * transmit enable and data, one beat per 160 ns link clock period.
 * Assumes core_clk runs at 4 ns; the link clock stands still when idle.
 */
module mac_model (
	// bench clock
	input  wire logic  core_clk,
	// transmit pins toward the device
	output logic       link_clk,
	output logic       tx_en,
	output logic [3:0] txd
);
	timeunit 1ns;
	timeprecision 100ps;

	// idle: clock low, enable low, data lines held at 5
	initial begin
		link_clk = 1'b0;
		tx_en    = 1'b0;
		txd      = 4'h5;
	end

	// one beat: data set in the low half and held across the rise
	task automatic beat(input logic [3:0] d, input logic en);
		@(posedge core_clk);
		tx_en <= en;
		txd   <= en ? d : ~txd;
		repeat (19) @(posedge core_clk);
		link_clk <= 1'b1;
		repeat (20) @(posedge core_clk);
		link_clk <= 1'b0;
	endtask
endmodule

// ==== testbench/tb_mii_pin_strap_led_logic.sv ====
/*
 * Self-checking bench for the transceiver pin logic: straps, pins,
 * indicators, MII/RMII transmit beats and RMII receive dibits.
 * Assumes mac_model drives the link pins; blink shortened to 8 cycles.
 */
module tb_mii_pin_strap_led_logic;
	timeunit 1ns;
	timeprecision 100ps;
	import mii_strap_pkg::*;
	logic            core_clk, reset_n, rmii_mode, s0, s1, s2, s_an, s_sp;
	logic            collision_det, carrier_sense, link_up, activity;
	logic            speed_100, rx_dibit_valid;
	logic [1:0]      led_mode, rx_dibit, p;
	wire logic       link_clk, tx_en, col_out, col_oe, crs_out, crs_oe;
	wire logic       link_ind, link_oe, spd_ind, spd_oe, rmii_crs_dv;
	wire logic       rx_dibit_ready, speed_select, strap_done;
	wire logic [3:0] txd;
	wire logic [1:0] rmii_rxd;
	tx_beat_t        tx_beat;
	strap_t          straps;
	int              mismatches, samples_checked, cycles, seed, k, rx_seen;
	logic [31:0]     r;
	logic [7:0]      note;
	logic [7:0]      exp_tx[$];
	logic [2:0]      exp_rx[$];

	// pin levels: device drives when enabled, else pull or strap level
	wire logic col_pin = col_oe ? col_out : s0;
	wire logic crs_pin = crs_oe ? crs_out : s1;
	wire logic an_pin  = link_oe ? link_ind : s_an;
	wire logic sp_pin  = spd_oe ? spd_ind : s_sp;

	mac_model mac (.core_clk(core_clk), .link_clk(link_clk),
		.tx_en(tx_en), .txd(txd));

	mii_pin_strap_led_logic #(.BLINK_CYCLES(8)) dut (
		.core_clk(core_clk), .reset_n(reset_n), .link_clk(link_clk),
		.tx_en(tx_en), .txd(txd), .rmii_mode(rmii_mode),
		.mode_strap_bit0_in(col_pin), .col_out(col_out), .col_oe(col_oe),
		.mode_strap_bit1_in(crs_pin), .crs_out(crs_out), .crs_oe(crs_oe),
		.mode_strap_bit2_in(s2), .autoneg_enable_strap(an_pin),
		.link_indicator_out(link_ind), .link_indicator_oe(link_oe),
		.speed_strap_in(sp_pin), .speed_activity_indicator_out(spd_ind),
		.speed_activity_indicator_oe(spd_oe), .rmii_rxd(rmii_rxd),
		.rmii_crs_dv(rmii_crs_dv), .collision_det(collision_det),
		.carrier_sense(carrier_sense), .link_up(link_up),
		.activity(activity), .speed_100(speed_100), .led_mode(led_mode),
		.rx_dibit_valid(rx_dibit_valid), .rx_dibit(rx_dibit),
		.rx_dibit_ready(rx_dibit_ready), .tx_beat(tx_beat),
		.straps(straps), .speed_select(speed_select),
		.strap_done(strap_done));

	// bench clock
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic end_of_test();
		$display("mismatches=%0d samples_checked=%0d", mismatches,
			samples_checked);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// hang guard
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			mismatches++;
			end_of_test();
		end
	end

	// compare each beat and dibit with the oldest note
	always @(posedge core_clk) begin
		if (tx_beat.valid === 1'b1) begin
			note = exp_tx.size() ? exp_tx.pop_front() : 8'hFF;
			chk({3'h0, tx_beat}, note);
		end
		if (rx_dibit_ready === 1'b1) begin
			rx_seen++;
			note = exp_rx.size() ? {5'h0, exp_rx.pop_front()} : 8'hFF;
			chk({5'h0, rmii_crs_dv, rmii_rxd}, note);
		end
	end

	// receive source: next dibit offered after each take
	always @(posedge core_clk) begin
		if (rx_dibit_ready === 1'b1) begin
			rx_dibit <= rx_dibit + 2'h1;
			exp_rx.push_back({1'b1, rx_dibit + 2'h1});
		end
	end

	// reset with given strap levels, then disturb the pins
	task automatic do_reset(input logic [2:0] code, input logic an, sp);
		strap_t e;
		logic [4:0] drv;
		e.mode_code = code;
		e.if_mode = code == MODE_CODE_MII ? IF_MII :
			code == MODE_CODE_B2B ? IF_B2B : IF_RESERVED;
		e.autoneg_enable = an;
		e.speed_100 = sp;
		@(posedge core_clk);
		reset_n <= 1'b0;
		{s2, s1, s0} <= code;
		s_an <= an;
		s_sp <= sp;
		repeat (2) @(posedge core_clk);
		#1 chk({col_oe, crs_oe, link_oe, spd_oe}, 8'h00);
		@(posedge core_clk);
		reset_n <= 1'b1;
		repeat (6) @(posedge core_clk);
		{s2, s1, s0} <= ~code;
		s_an <= ~an;
		s_sp <= ~sp;
		repeat (6) @(posedge core_clk);
		#1 chk(straps, e);
		chk({7'h0, speed_select}, {7'h0, sp});
		drv = {1'b1, ~rmii_mode, ~rmii_mode, 2'h3};
		chk({strap_done, col_oe, crs_oe, link_oe, spd_oe}, drv);
	endtask

	// activity blink on the chosen indicator
	task automatic blink(input logic [1:0] m);
		int hi;
		int lo;
		hi = 0;
		lo = 0;
		@(posedge core_clk);
		led_mode <= m;
		link_up <= 1'b1;
		activity <= 1'b1;
		repeat (24) begin
			@(posedge core_clk);
			if ((m == 2'h0 ? link_ind : spd_ind) === 1'b1) hi++;
			else lo++;
		end
		chk({6'h0, hi != 0, lo != 0}, 8'h03);
		activity <= 1'b0;
	endtask

	// main sequence
	initial begin
		seed = 32'hB359;
		{mismatches, samples_checked, cycles, k, rx_seen} = '0;
		{reset_n, rmii_mode, s0, s1, s2, s_an, s_sp} = 7'h3;
		{collision_det, carrier_sense, link_up, activity} = 4'h0;
		{speed_100, rx_dibit_valid, led_mode, rx_dibit, p} = 8'h0;
		for (int i = 0; i < 3; i++) begin
			r = $random(seed);
			do_reset(i == 0 ? 3'h0 : i == 1 ? 3'h6 : r[2:0] | 3'h1, r[3], r[4]);
		end
		for (int i = 0; i < 8; i++) begin
			r = $random(seed);
			@(posedge core_clk);
			collision_det <= r[0];
			carrier_sense <= r[1];
			repeat (2) @(posedge core_clk);
			#1 chk({6'h0, col_out, crs_out}, {6'h0, r[0], r[1]});
		end
		for (int i = 0; i < 16; i++) begin
			r = $random(seed);
			@(posedge core_clk);
			led_mode <= 2'(i);
			link_up <= r[0];
			speed_100 <= r[1];
			repeat (3) @(posedge core_clk);
			#1 chk({6'h0, link_ind, spd_ind}, i[1] ? 8'h03 : {6'h0, ~r[0], i[0] | ~r[1]});
		end
		blink(2'h0);
		blink(2'h1);
		for (int i = 0; i < 6; i++) begin
			r = $random(seed);
			if (i != 3) exp_tx.push_back({4'h1, r[3:0]});
			mac.beat(r[3:0], i != 3);
		end
		rmii_mode <= 1'b1;
		rx_dibit_valid <= 1'b1;
		exp_rx.push_back(3'h4);
		mac.beat(4'h0, 1'b0);
		for (int i = 0; i < 8; i++) begin
			r = $random(seed);
			if (i == 5) k = 0;
			else if (k++ % 2 == 1) exp_tx.push_back({4'h1, r[1:0], p});
			p = r[1:0];
			mac.beat(r[3:0], i != 5);
		end
		rx_dibit_valid <= 1'b0;
		rmii_mode <= 1'b0;
		repeat (10) @(posedge core_clk);
		exp_rx.delete();
		chk(8'(exp_tx.size()), 8'h00);
		chk(8'(rx_seen), 8'h09);
		end_of_test();
	end
endmodule
